// ===== src/loop_ctrl_pkg.sv
// Purpose: Shared constants for the port loopback control block
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   Per-port registers sit at a group base plus four per port
package loop_ctrl_pkg;

	// Register groups, byte addresses
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h00; // Sticky events, W1C
	localparam logic [7:0] IRQ_MASK_ADDR   = 8'h04; // Event enables
	localparam logic [3:0] GRP_MISC        = 4'h0;  // Status and mask group
	localparam logic [3:0] GRP_CTRL        = 4'h1;  // Port control at 0x10
	localparam logic [3:0] GRP_STAT        = 4'h3;  // Port status at 0x30
	localparam logic [3:0] GRP_DISCARD     = 4'h5;  // Discard count at 0x50

	// Port control fields
	localparam int CTRL_MAINT_BIT   = 0; // Maintenance service request
	localparam int CTRL_LOOP_LSB    = 1; // Requested loop, two bits
	localparam int CTRL_ALARM_BIT   = 3; // Alarm while looped

	// Port status fields
	localparam int STAT_SVC_LSB     = 0; // Service state, two bits
	localparam int STAT_FAC_BIT     = 2; // Facility loop condition
	localparam int STAT_TERM_BIT    = 3; // Terminal loop condition
	localparam int STAT_SUPPR_BIT   = 4; // Alarms suppressed condition
	localparam int STAT_AIS_BIT     = 5; // Alarm indication sent down or out to the span
	localparam int STAT_AGG_BIT     = 6; // Hit by trunk aggregate loop

	// Reset values
	localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

	// Service states of a port
	typedef enum logic [1:0] {
		SVC_IN_SERVICE = 2'b00, // Normal traffic
		SVC_MAINT      = 2'b01, // maint_out_of_service_state
		SVC_LOOP_MAINT = 2'b10  // loop_maint_out_of_service_state
	} svc_t;

	// Loopback kinds
	typedef enum logic [1:0] {
		LOOP_NONE     = 2'b00, // Forward path
		LOOP_FACILITY = 2'b01, // Line receive back out to the span
		LOOP_TERMINAL = 2'b10, // Inward traffic back inward
		LOOP_ILLEGAL  = 2'b11  // Refused code
	} loop_t;

endpackage : loop_ctrl_pkg

// ===== src/loop_port_path.sv
// Purpose: One port's datapath: forward, facility or terminal loop
// Assumes: Both streams on pclk; loop kind stable from control logic
// Notes:   Outputs registered; alarm indication is an all-ones word
module loop_port_path
	import loop_ctrl_pkg::*;
#(
	parameter int   DATA_W      = 8,
	parameter logic BRIDGE_FAC  = 1'b0, // Facility loop bridged
	parameter logic BRIDGE_TERM = 1'b1  // Terminal loop bridged
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire loop_t             loop_mode,
	input  wire logic [DATA_W-1:0] line_rx_data,
	input  wire logic              line_rx_valid,
	input  wire logic [DATA_W-1:0] fwd_data,
	input  wire logic              fwd_valid,
	output logic      [DATA_W-1:0] line_tx_data,
	output logic                   line_tx_valid,
	output logic      [DATA_W-1:0] down_data,
	output logic                   down_valid,
	output logic                   ais_active
);

	localparam logic [DATA_W-1:0] AIS_WORD = '1; // Alarm indication fill

	// Steer both directions by loop kind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_tx_data  <= '0;
			line_tx_valid <= 1'b0;
			down_data     <= '0;
			down_valid    <= 1'b0;
			ais_active    <= 1'b0;
		end else if (ce) begin
			unique case (loop_mode)
				LOOP_FACILITY: begin
					// Received line signal goes back out to the span
					line_tx_data  <= line_rx_data;
					line_tx_valid <= line_rx_valid;
					// Copy down when bridged, else alarm fill
					down_data     <= BRIDGE_FAC ? line_rx_data
						: AIS_WORD;
					down_valid    <= BRIDGE_FAC ? line_rx_valid : 1'b1;
					ais_active    <= !BRIDGE_FAC;
				end
				LOOP_TERMINAL: begin
					// Inward traffic turned back inward
					down_data     <= fwd_data;
					down_valid    <= fwd_valid;
					line_tx_data  <= BRIDGE_TERM ? fwd_data : AIS_WORD;
					line_tx_valid <= BRIDGE_TERM ? fwd_valid : 1'b1;
					ais_active    <= !BRIDGE_TERM;
				end
				default: begin
					// Normal forward path restored
					line_tx_data  <= fwd_data;
					line_tx_valid <= fwd_valid;
					down_data     <= line_rx_data;
					down_valid    <= line_rx_valid;
					ais_active    <= 1'b0;
				end
			endcase
		end
	end

endmodule : loop_port_path

// ===== src/port_facility_loopback_control.sv
// Purpose: Loopback control for client and trunk ports of a line card
// Assumes: Ports 0..NUM_CLIENTS-1 are clients, the rest are trunks
// Notes:   Loops are set over APB; pready waits one setup cycle
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module port_facility_loopback_control
	import loop_ctrl_pkg::*;
#(
	parameter int                     NUM_PORTS   = 4,
	parameter int                     NUM_CLIENTS = 2,
	parameter int                     DATA_W      = 8,
	parameter int                     CNT_W       = 32,
	parameter logic [NUM_PORTS-1:0]   SDH_PORT    = '0,
	parameter logic [NUM_PORTS-1:0]   BRIDGE_FAC  = 4'b0011,
	parameter logic [NUM_PORTS-1:0]   BRIDGE_TERM = 4'b1111
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              ce,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [7:0]                        paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	output logic                                   irq,
	input  wire logic [NUM_PORTS-1:0][DATA_W-1:0]  line_rx_data,
	input  wire logic [NUM_PORTS-1:0]              line_rx_valid,
	input  wire logic [NUM_PORTS-1:0][DATA_W-1:0]  fwd_data,
	input  wire logic [NUM_PORTS-1:0]              fwd_valid,
	output logic      [NUM_PORTS-1:0][DATA_W-1:0]  line_tx_data,
	output logic      [NUM_PORTS-1:0]              line_tx_valid,
	output logic      [NUM_PORTS-1:0][DATA_W-1:0]  down_data,
	output logic      [NUM_PORTS-1:0]              down_valid,
	input  wire logic [NUM_PORTS-1:0]              line_alarm_pin,
	output logic      [NUM_PORTS-1:0]              line_alarm,
	output logic      [NUM_PORTS-1:0]              facility_loop_condition,
	output logic      [NUM_PORTS-1:0]              terminal_loop_condition,
	output logic      [NUM_PORTS-1:0]
		alarms_suppressed_maint_condition
);

	svc_t                         svc       [NUM_PORTS]; // Service state
	loop_t                        loop_mode [NUM_PORTS]; // Active loop
	loop_t                        eff_mode  [NUM_PORTS]; // Path steering
	logic [NUM_PORTS-1:0]         maint_req;   // Maintenance requested
	logic [NUM_PORTS-1:0]         alarm_loop;  // Alarm while looped
	logic [NUM_PORTS-1:0]         ais_active;  // Indication per port
	logic [NUM_PORTS-1:0]         agg_hit;     // Trunk loop reaches client
	logic [CNT_W-1:0]             discard   [NUM_PORTS]; // Ingress drops
	logic [NUM_PORTS-1:0]         alarm_meta;  // Sync stage one
	logic [NUM_PORTS-1:0]         alarm_sync;  // Sync stage two
	logic [2*NUM_PORTS-1:0]       irq_status;  // Sticky events
	logic [2*NUM_PORTS-1:0]       irq_mask;    // Event enables
	logic [NUM_PORTS-1:0]         ev_refuse;   // Loop request refused
	logic [NUM_PORTS-1:0]         ev_change;   // Loop came or went
	logic                         setup_done;  // Read data latched
	logic                         wr_en;       // APB write completes
	logic                         addr_ok;     // Address is mapped
	logic                         any_trunk_term; // Aggregate loop
	logic [31:0]                  next_rdata;  // Read mux
	logic [NUM_PORTS-1:0]         pwdata_q_nz; // Request carried a loop

	// True when paddr is port p's register in the given group
	function automatic logic hit_port(input logic [7:0] a,
		input logic [3:0] grp, input int p);
		hit_port = (a[7:4] == grp) && (int'(a[3:2]) == p)
			&& (a[1:0] == 2'b00);
	endfunction : hit_port

	// Address map check
	always_comb begin
		addr_ok = (paddr == IRQ_STATUS_ADDR) || (paddr == IRQ_MASK_ADDR);
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (hit_port(paddr, GRP_CTRL, p) || hit_port(paddr, GRP_STAT, p)
				|| hit_port(paddr, GRP_DISCARD, p)) begin
				addr_ok = 1'b1;
			end
		end
	end

	// Answer one cycle after setup; ce low stalls the answer
	assign pready  = ce && setup_done;
	assign pslverr = pready && !addr_ok;
	assign wr_en   = psel && penable && pwrite && pready && addr_ok;

	// Read mux, captured in the setup cycle
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (paddr == IRQ_STATUS_ADDR) begin
			next_rdata[2*NUM_PORTS-1:0] = irq_status;
		end else if (paddr == IRQ_MASK_ADDR) begin
			next_rdata[2*NUM_PORTS-1:0] = irq_mask;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (hit_port(paddr, GRP_CTRL, p)) begin
				next_rdata[CTRL_MAINT_BIT]              = maint_req[p];
				next_rdata[CTRL_LOOP_LSB+:2]            = loop_mode[p];
				next_rdata[CTRL_ALARM_BIT]              = alarm_loop[p];
			end
			if (hit_port(paddr, GRP_STAT, p)) begin
				next_rdata[STAT_SVC_LSB+:2] = svc[p];
				next_rdata[STAT_FAC_BIT]    = facility_loop_condition[p];
				next_rdata[STAT_TERM_BIT]   = terminal_loop_condition[p];
				next_rdata[STAT_SUPPR_BIT]  =
					alarms_suppressed_maint_condition[p];
				next_rdata[STAT_AIS_BIT]    = ais_active[p];
				next_rdata[STAT_AGG_BIT]    = agg_hit[p];
			end
			if (hit_port(paddr, GRP_DISCARD, p)) begin
				next_rdata[CNT_W-1:0] = discard[p];
			end
		end
	end

	// APB phase tracking and read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_done <= 1'b0;
			prdata     <= 32'h0000_0000;
		end else if (ce) begin
			if (psel && !penable) begin
				// Setup cycle: latch read data
				setup_done <= 1'b1;
				prdata     <= next_rdata;
			end else if (pready) begin
				// Transfer done
				setup_done <= 1'b0;
			end
		end
	end

	// Per-port service state and loop control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				svc[p]       <= SVC_IN_SERVICE;
				loop_mode[p] <= LOOP_NONE;
			end
			maint_req  <= '0;
			alarm_loop <= '0;
			ev_refuse  <= '0;
			ev_change  <= '0;
		end else if (ce) begin
			ev_refuse <= '0;
			ev_change <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				// Only the addressed port changes state
				if (wr_en && hit_port(paddr, GRP_CTRL, p)) begin
					maint_req[p]  <= pwdata[CTRL_MAINT_BIT];
					alarm_loop[p] <= pwdata[CTRL_ALARM_BIT];
					if (!pwdata[CTRL_MAINT_BIT]) begin
						// Back in service; any loop is dropped
						svc[p]       <= SVC_IN_SERVICE;
						loop_mode[p] <= LOOP_NONE;
						ev_change[p] <= (loop_mode[p] != LOOP_NONE);
					end else if (loop_t'(pwdata[CTRL_LOOP_LSB+:2])
						== LOOP_NONE) begin
						// Loop removed, port stays in maintenance
						svc[p]       <= SVC_MAINT;
						loop_mode[p] <= LOOP_NONE;
						ev_change[p] <= (loop_mode[p] != LOOP_NONE);
					end else if (svc[p] == SVC_IN_SERVICE
						|| loop_t'(pwdata[CTRL_LOOP_LSB+:2]) == LOOP_ILLEGAL)
						begin
						// Refused; a held loop keeps loop-maintenance
						svc[p]       <= (loop_mode[p] == LOOP_NONE)
							? SVC_MAINT : SVC_LOOP_MAINT;
						ev_refuse[p] <= 1'b1;
					end else begin
						// Loop created, port enters loop-maintenance
						svc[p]       <= SVC_LOOP_MAINT;
						loop_mode[p] <= loop_t'(pwdata[CTRL_LOOP_LSB+:2]);
						ev_change[p] <= (loop_mode[p] !=
							loop_t'(pwdata[CTRL_LOOP_LSB+:2]));
					end
				end
			end
		end
	end

	// A trunk terminal loop acts on the aggregate carrying all clients
	always_comb begin
		any_trunk_term = 1'b0;
		for (int p = NUM_CLIENTS; p < NUM_PORTS; p++) begin
			if (loop_mode[p] == LOOP_TERMINAL) begin
				any_trunk_term = 1'b1;
			end
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			agg_hit[p]  = (p < NUM_CLIENTS) && any_trunk_term;
			eff_mode[p] = (agg_hit[p] && loop_mode[p] == LOOP_NONE)
				? LOOP_TERMINAL : loop_mode[p];
			facility_loop_condition[p] =
				(loop_mode[p] == LOOP_FACILITY);
			terminal_loop_condition[p] = (loop_mode[p] == LOOP_TERMINAL);
			alarms_suppressed_maint_condition[p] =
				(loop_mode[p] != LOOP_NONE) && !alarm_loop[p];
		end
	end

	// Line alarm pins pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_meta <= '0;
			alarm_sync <= '0;
		end else if (ce) begin
			alarm_meta <= line_alarm_pin;
			alarm_sync <= alarm_meta;
		end
	end

	// Alarm reporting, muted while suppressed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_alarm <= '0;
		end else if (ce) begin
			line_alarm <= alarm_sync
				& ~alarms_suppressed_maint_condition;
		end
	end

	// Ingress discard counters run while a facility loop holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				discard[p] <= '0;
			end
		end else if (ce) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (facility_loop_condition[p] && line_rx_valid[p]) begin
					discard[p] <= discard[p] + CNT_W'(1);
				end
			end
		end
	end

	// Interrupt status: set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq_mask   <= IRQ_MASK_RESET[2*NUM_PORTS-1:0];
		end else if (ce) begin
			if (wr_en && paddr == IRQ_MASK_ADDR) begin
				irq_mask <= pwdata[2*NUM_PORTS-1:0];
			end
			irq_status <= (irq_status & ~((wr_en
				&& paddr == IRQ_STATUS_ADDR) ? pwdata[2*NUM_PORTS-1:0]
				: '0)) | {ev_change, ev_refuse};
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Per-port datapaths with fixed terminate or bridge choice
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		loop_port_path #(
			.DATA_W      (DATA_W),
			.BRIDGE_FAC  (BRIDGE_FAC[g]),
			.BRIDGE_TERM (BRIDGE_TERM[g])
		) u_path (
			.pclk          (pclk),
			.presetn       (presetn),
			.ce            (ce),
			.loop_mode     (eff_mode[g]),
			.line_rx_data  (line_rx_data[g]),
			.line_rx_valid (line_rx_valid[g]),
			.fwd_data      (fwd_data[g]),
			.fwd_valid     (fwd_valid[g]),
			.line_tx_data  (line_tx_data[g]),
			.line_tx_valid (line_tx_valid[g]),
			.down_data     (down_data[g]),
			.down_valid    (down_valid[g]),
			.ais_active    (ais_active[g])
		);

		chk_refuse_no_maint: assert property (
			@(posedge pclk) disable iff (!presetn)
			(wr_en && hit_port(paddr, GRP_CTRL, g) && svc[g] ==
				SVC_IN_SERVICE) |=> (loop_mode[g] == LOOP_NONE
				&& ev_refuse[g] == $past(pwdata_q_nz[g])))
			else $error("loop created without maintenance state");

		chk_loop_state: assert property (
			@(posedge pclk) disable iff (!presetn)
			(loop_mode[g] != LOOP_NONE) |-> (svc[g] == SVC_LOOP_MAINT))
			else $error("looped port not in loop maintenance");

		chk_fac_outward: assert property (
			@(posedge pclk) disable iff (!presetn)
			(ce && eff_mode[g] == LOOP_FACILITY)
			|=> (line_tx_data[g] == $past(line_rx_data[g])))
			else $error("facility loop not returned to span");

		chk_down_path: assert property (
			@(posedge pclk) disable iff (!presetn)
			(ce && eff_mode[g] == LOOP_FACILITY) |=> (down_data[g] ==
				(BRIDGE_FAC[g] ? $past(line_rx_data[g]) : '1)))
			else $error("downstream copy or block wrong");

		chk_ais_insert: assert property (
			@(posedge pclk) disable iff (!presetn)
			(ce && eff_mode[g] == LOOP_FACILITY)
			|=> (ais_active[g] == !BRIDGE_FAC[g]))
			else $error("alarm indication wrong for loop kind");

		chk_fac_report: assert property (
			@(posedge pclk) disable iff (!presetn)
			facility_loop_condition[g] |-> (svc[g] == SVC_LOOP_MAINT
				&& !terminal_loop_condition[g]))
			else $error("facility condition without loop state");

		chk_alarm_muted: assert property (
			@(posedge pclk) disable iff (!presetn)
			(ce && loop_mode[g] != LOOP_NONE && !alarm_loop[g])
			|=> !line_alarm[g])
			else $error("alarm passed during suppressed loop");

		chk_discard_count: assert property (
			@(posedge pclk) disable iff (!presetn)
			(ce && facility_loop_condition[g] && line_rx_valid[g])
			|=> (discard[g] == $past(discard[g]) + CNT_W'(1)))
			else $error("discard counter did not advance");

		chk_loop_removed: assert property (
			@(posedge pclk) disable iff (!presetn)
			(wr_en && hit_port(paddr, GRP_CTRL, g)
				&& pwdata[CTRL_LOOP_LSB+:2] == 2'b00)
			|=> (loop_mode[g] == LOOP_NONE && svc[g] != SVC_LOOP_MAINT)
			##1 (!ais_active[g] || $past(agg_hit[g]) || !$past(ce)))
			else $error("loop not fully removed");
	end

	// Helper for the refusal check: a loop was asked for
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			pwdata_q_nz[p] = (pwdata[CTRL_LOOP_LSB+:2] != 2'b00)
				&& pwdata[CTRL_MAINT_BIT];
		end
	end

endmodule : port_facility_loopback_control

// ===== testbench/loop_test_set.sv
// Purpose: Line-side test set feeding every port of the loop block
// Assumes: Streams move on pclk, one word per cycle, always valid
// Notes:   Top data bit kept low so no word can mimic all-ones AIS
module loop_test_set
	import loop_ctrl_pkg::*;
#(
	parameter int NUM_PORTS = 4,
	parameter int DATA_W    = 8
) (
	input  wire logic                             pclk,
	input  wire logic                             presetn,
	output logic     [NUM_PORTS-1:0][DATA_W-1:0] line_rx_data,
	output logic     [NUM_PORTS-1:0]             line_rx_valid,
	output logic     [NUM_PORTS-1:0][DATA_W-1:0] fwd_data,
	output logic     [NUM_PORTS-1:0]             fwd_valid
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [6:0] count; // Pattern seed, steps every cycle

	// Step the pattern so each cycle carries a new word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 7'h00;
		end else begin
			count <= count + 7'h01;
		end
	end

	// Distinct words per port and per direction
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			line_rx_data[p] = DATA_W'({1'b0, count ^ 7'(p)});
			fwd_data[p]     = DATA_W'({1'b0, ~count ^ 7'(p)});
		end
		line_rx_valid = '1;
		fwd_valid     = '1;
	end
endmodule : loop_test_set

// ===== testbench/port_facility_loopback_control_bench.sv
// Purpose: Self-checking bench for the port loopback control block
// Assumes: Default sizes: ports 0,1 client, 2,3 trunk; ce high except in the clock enable test
// Notes:   Datapath compared at the falling edge against last inputs
module port_facility_loopback_control_bench
	import loop_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int P  = 4; // Ports
	localparam int DW = 8; // Word width

	logic                  pclk, presetn, ce;   // Clock, reset, enable
	logic                  psel, penable, pwrite; // APB controls
	logic [7:0]            paddr;               // APB address
	logic [31:0]           pwdata, prdata;      // APB data
	logic                  pready, pslverr, irq; // Slave answers
	logic [P-1:0][DW-1:0]  line_rx_data, fwd_data;     // Into the card
	logic [P-1:0]          line_rx_valid, fwd_valid;   // Their valids
	logic [P-1:0][DW-1:0]  line_tx_data, down_data;    // Out of card
	logic [P-1:0]          line_tx_valid, down_valid;  // Their valids
	logic [P-1:0]          line_alarm_pin, line_alarm; // Alarm in, out
	logic [P-1:0]          facility_loop_condition;    // Conditions
	logic [P-1:0]          terminal_loop_condition;
	logic [P-1:0]          alarms_suppressed_maint_condition;
	logic [P-1:0][DW-1:0]  prev_rx, prev_fwd;   // Inputs one edge ago
	logic [31:0]           q, q2;               // Read results
	logic                  err;                 // Last pslverr
	int                    bad_count, checks;   // Tallies

	port_facility_loopback_control u_dut (.*);
	loop_test_set u_set (.pclk(pclk), .presetn(presetn),
		.line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
		.fwd_data(fwd_data), .fwd_valid(fwd_valid));

	// Clock at 100 ns
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Remember inputs for one-cycle datapath checks
	always_ff @(posedge pclk) begin
		prev_rx  <= line_rx_data;
		prev_fwd <= fwd_data;
	end

	// Print verdict and stop
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// Compare one value
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t ns: got %0h want %0h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready seen high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) begin
			bad_count++;
			$display("[FAIL] %0t ns: no pready", $time);
			complete_run();
		end
		e = pslverr;
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Write and read shorthands
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		apb(1'b1, a, d, dummy, err);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		apb(1'b0, a, 32'h0000_0000, d, err);
	endtask : rd

	// Byte address of a port register
	function automatic logic [7:0] reg_at(logic [3:0] g, int p);
		return {g, 4'h0} + 8'(4 * p);
	endfunction : reg_at

	// Cut a hang short
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		complete_run();
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		line_alarm_pin = 4'b0100;
		ce = 1'b1;
		presetn = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		rd(IRQ_MASK_ADDR, q);
		chk(q, IRQ_MASK_RESET);
		rd(reg_at(GRP_STAT, 0), q);
		chk(q, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		$display("test reset done");
		// Loop asked while in service, then illegal code
		wr(IRQ_MASK_ADDR, 32'h0000_00FF);
		wr(reg_at(GRP_CTRL, 0), 32'h0000_0003);
		rd(IRQ_STATUS_ADDR, q);
		chk(q, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		rd(reg_at(GRP_STAT, 0), q);
		chk(q, 32'h0000_0001);
		wr(IRQ_STATUS_ADDR, 32'h0000_00FF);
		wr(reg_at(GRP_CTRL, 0), 32'h0000_0007);
		rd(IRQ_STATUS_ADDR, q);
		chk(q, 32'h0000_0001);
		wr(IRQ_STATUS_ADDR, 32'h0000_00FF);
		rd(IRQ_STATUS_ADDR, q);
		chk(q, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		$display("test refusal done");
		// Terminated facility loop on trunk port 2
		wr(reg_at(GRP_CTRL, 2), 32'h0000_0001);
		wr(reg_at(GRP_CTRL, 2), 32'h0000_0003);
		rd(IRQ_STATUS_ADDR, q);
		chk(32'(q[6]), 32'h0000_0001);
		rd(reg_at(GRP_STAT, 2), q);
		chk(q, 32'h0000_0036);
		@(negedge pclk);
		chk(32'(line_tx_data[2]), 32'(prev_rx[2]));
		chk(32'(down_data[2]), 32'h0000_00FF);
		chk(32'(facility_loop_condition), 32'h0000_0004);
		chk(32'(alarms_suppressed_maint_condition), 32'h4);
		chk(32'(line_alarm[2]), 32'h0000_0000);
		rd(reg_at(GRP_DISCARD, 2), q);
		rd(reg_at(GRP_DISCARD, 2), q2);
		chk(32'(q2 > q), 32'h0000_0001);
		rd(reg_at(GRP_DISCARD, 3), q);
		chk(q, 32'h0000_0000);
		$display("test trunk facility done");
		// Bridged facility loop on client port 0
		wr(reg_at(GRP_CTRL, 0), 32'h0000_0003);
		rd(reg_at(GRP_STAT, 0), q);
		chk(q, 32'h0000_0016);
		rd(reg_at(GRP_STAT, 1), q);
		chk(q, 32'h0000_0000);
		wr(reg_at(GRP_CTRL, 0), 32'h0000_0007);
		rd(reg_at(GRP_STAT, 0), q);
		chk(q, 32'h0000_0016);
		@(negedge pclk);
		chk(32'(down_data[0]), 32'(prev_rx[0]));
		chk(32'(line_tx_data[0]), 32'(prev_rx[0]));
		$display("test client facility done");
		// Alarm while looped, then removal
		wr(reg_at(GRP_CTRL, 2), 32'h0000_000B);
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk(32'(line_alarm[2]), 32'h0000_0001);
		chk(32'(alarms_suppressed_maint_condition[2]), 32'h0);
		wr(reg_at(GRP_CTRL, 2), 32'h0000_0000);
		rd(reg_at(GRP_STAT, 2), q);
		chk(q, 32'h0000_0000);
		@(negedge pclk);
		chk(32'(down_data[2]), 32'(prev_rx[2]));
		chk(32'(line_tx_data[2]), 32'(prev_fwd[2]));
		$display("test removal done");
		// Terminal loop on trunk port 3 hits unlooped clients
		wr(reg_at(GRP_CTRL, 3), 32'h0000_0001);
		wr(reg_at(GRP_CTRL, 3), 32'h0000_0005);
		rd(reg_at(GRP_STAT, 3), q);
		chk(q, 32'h0000_001A);
		rd(reg_at(GRP_STAT, 1), q);
		chk(32'(q[STAT_AGG_BIT]), 32'h0000_0001);
		@(negedge pclk);
		chk(32'(terminal_loop_condition), 32'h0000_0008);
		chk(32'(line_tx_data[3]), 32'(prev_fwd[3]));
		chk(32'(down_data[3]), 32'(prev_fwd[3]));
		chk(32'(down_data[1]), 32'(prev_fwd[1]));
		chk(32'(line_tx_valid & down_valid), 32'h0000_000F);
		$display("test trunk terminal done");
		// Clock enable low freezes the datapath
		@(posedge pclk);
		ce <= 1'b0;
		@(negedge pclk);
		q = 32'(line_tx_data[3]);
		repeat (2) @(negedge pclk);
		chk(32'(line_tx_data[3]), q);
		@(posedge pclk);
		ce <= 1'b1;
		$display("test clock enable done");
		// Unmapped address is refused
		rd(8'hF0, q);
		chk(32'(err), 32'h0000_0001);
		chk(q, 32'h0000_0000);
		wr(8'hF0, 32'h0000_0001);
		chk(32'(err), 32'h0000_0001);
		$display("test unmapped done");
		complete_run();
	end
endmodule : port_facility_loopback_control_bench
